// *** lspd_ctrl_model.sv ***
// Purpose: Controller model for the dimming pin and fault flags
// Assumes: Pin period of 100 clocks
// Notes: A released pin reads high through its pull-up
`timescale 1ns/1ps
module lspd_ctrl_model (
    input wire logic clk,
    input wire logic drive,
    input wire logic [6:0] duty,
    input wire logic fault_n,
    input wire logic [1:0] open_circuit_flags,
    input wire logic [1:0] short_circuit_flags,
    output logic ext_dim_pin = 1'b1,
    output logic [1:0] seen = 2'h0
);
    logic [6:0] cnt_q = 7'h00;
    always @(negedge clk) begin
        cnt_q <= (cnt_q == 7'h63) ? 7'h00 : cnt_q + 7'h01;
        ext_dim_pin <= drive ? (cnt_q < duty) : 1'b1;
        if (!fault_n) seen <= open_circuit_flags | short_circuit_flags;
    end
endmodule : lspd_ctrl_model

// *** lspd_dimming.sv ***
// Purpose: Per-string PWM dimming with phase delay, global intensity and fault output.
// Assumes: Inputs from pins are asynchronous; configuration ports are synchronous.
// Notes: Fault detection comparators live outside; their flags arrive as levels.
// Notes: String intensity and phase are taken at each frame start; divider and gated-mode changes act at once.
// Function
// - Each string turns on its phase delay count of grayscale pulses after frame start.
// - Zero phase delay starts the on-time exactly at frame start.
// - Three modes; internal mode ignores the external dimming input.
// - Internal mode scales per-string intensity by global intensity 0 to 3F.
// - External and gated modes replace global intensity with measured input duty.
// - Gated mode lets strings follow their on-time while input is high, and holds all strings off when low.
// - Driver runs while enable is high, shuts off when low.
// - Open or shorted strings drive the active-low fault output low.
// - Frame rate is the 2.5 MHz base divided by a 16-bit divider.
// - On-time is the top eight bits of intensity times global, in count periods.
`timescale 1ns/1ps
module lspd_dimming
    import lspd_pkg::*;
#(
    parameter int NSTR = STRINGS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic enable_pin,
    input wire logic ext_dim_pin,
    input wire lspd_mode_type dimming_mode,
    input wire logic [FRAME_DIV_W-1:0] frame_rate_divider,
    input wire logic [COUNT_DIV_W-1:0] count_clock_divider,
    input wire logic [GLOBAL_W-1:0] global_intensity,
    input wire logic [NSTR*INT_W-1:0] string_intensity,
    input wire logic [NSTR*PHASE_W-1:0] string_phase_delay,
    input wire logic [NSTR-1:0] open_detect,
    input wire logic [NSTR-1:0] short_detect,
    output logic [NSTR-1:0] string_cathode_outputs,
    output logic [NSTR-1:0] open_circuit_flags,
    output logic [NSTR-1:0] short_circuit_flags,
    output logic [GLOBAL_W-1:0] measured_global,
    output logic fault_n
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic en_s1_q, en_s2_q, dim_s1_q, dim_s2_q;

    // Enable resets low so nothing lights before the pin is seen high
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_s1_q <= 1'b0;
            en_s2_q <= 1'b0;
        end else begin
            en_s1_q <= enable_pin;
            en_s2_q <= en_s1_q;
        end
    end

    // Dimming pin resets high to match its pull-up: no false low after reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dim_s1_q <= 1'b1;
            dim_s2_q <= 1'b1;
        end else begin
            dim_s1_q <= ext_dim_pin;
            dim_s2_q <= dim_s1_q;
        end
    end

    // ****************************************
    // Mode decode
    // ****************************************
    // Any code other than internal takes the global level from the pin,
    // so an illegal code falls back toward the external source
    wire run = en_s2_q;
    wire internal_mode = (dimming_mode == LSPD_MODE_INTERNAL);
    wire ext_used = !internal_mode;
    wire gated = (dimming_mode == LSPD_MODE_GATED);

    // ****************************************
    // Base tick, frame and count clocks
    // ****************************************
    logic [BASE_CNT_W-1:0] base_q;
    logic [FRAME_DIV_W-1:0] frame_cnt_q;
    logic [COUNT_DIV_W-1:0] gsc_cnt_q;
    // Divider values of zero behave as one so the counters never stall
    wire base_tick = (base_q == BASE_CNT_W'(BASE_DIV - 1));
    wire [FRAME_DIV_W-1:0] frame_last = (frame_rate_divider == '0) ? '0
                                      : frame_rate_divider - 1'b1;
    wire [COUNT_DIV_W-1:0] gsc_last = (count_clock_divider == '0) ? '0
                                    : count_clock_divider - 1'b1;
    wire frame_start = base_tick && (frame_cnt_q == frame_last);
    wire gsc_tick = base_tick && (gsc_cnt_q == gsc_last);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            base_q <= '0;
            frame_cnt_q <= '0;
            gsc_cnt_q <= '0;
        end else begin
            base_q <= base_tick ? '0 : base_q + 1'b1;
            if (base_tick) begin
                frame_cnt_q <= frame_start ? '0 : frame_cnt_q + 1'b1;
                // Count clock realigns to every frame so phasing is repeatable
                gsc_cnt_q <= (frame_start || gsc_tick) ? '0 : gsc_cnt_q + 1'b1;
            end
        end
    end

    // ****************************************
    // External duty measurement
    // ****************************************
    // High and total samples over one frame; scaled to 0..3F at frame end.
    // The frame-start tick is not sampled, so total is the divider minus one.
    // A zero total reads as zero duty rather than dividing by zero.
    // The measured level lags the pin by one whole frame.
    logic [DUTY_W-1:0] high_q, total_q;
    logic [GLOBAL_W-1:0] meas_q;
    wire [DUTY_W+GLOBAL_W-1:0] scaled = high_q * GLOBAL_MAX;
    wire [DUTY_W+GLOBAL_W-1:0] duty_full = (total_q == '0) ? '0 : scaled / total_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            high_q <= '0;
            total_q <= '0;
            meas_q <= GLOBAL_MAX;
        end else if (base_tick) begin
            if (frame_start) begin
                meas_q <= duty_full[GLOBAL_W-1:0];
                high_q <= '0;
                total_q <= '0;
            end else begin
                high_q <= high_q + {{(DUTY_W-1){1'b0}}, dim_s2_q};
                total_q <= total_q + 1'b1;
            end
        end
    end
    assign measured_global = meas_q;
    wire [GLOBAL_W-1:0] eff_global = ext_used ? meas_q : global_intensity;

    // ****************************************
    // Per-string phase and on-time counters
    // ****************************************
    logic [NSTR-1:0] on_q;
    generate
        for (genvar i = 0; i < NSTR; i++) begin : g_str
            logic [PHASE_W-1:0] dly_q;
            logic [INT_W-1:0] ton_q;
            logic wait_q;
            wire [PHASE_W-1:0] phase = string_phase_delay[i*PHASE_W +: PHASE_W];
            wire [INT_W+GLOBAL_W-1:0] prod = string_intensity[i*INT_W +: INT_W] * eff_global;
            // Product divided by 64: keep the top eight bits
            wire [INT_W-1:0] ton = prod[INT_W+GLOBAL_W-1 -: INT_W];
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    dly_q <= '0;
                    ton_q <= '0;
                    wait_q <= 1'b0;
                    on_q[i] <= 1'b0;
                end else if (frame_start) begin
                    // Frame start wins over a pending count tick: a phase plus
                    // on-time longer than the frame is cut here, not carried on.
                    // A zero on-time keeps the string dark for the whole frame.
                    ton_q <= ton;
                    dly_q <= phase;
                    wait_q <= (phase != '0);
                    on_q[i] <= (phase == '0) && (ton != '0);
                end else if (gsc_tick) begin
                    if (wait_q) begin
                        if (dly_q == 8'h01) begin
                            wait_q <= 1'b0;
                            on_q[i] <= (ton_q != '0);
                        end
                        dly_q <= dly_q - 1'b1;
                    end else if (on_q[i]) begin
                        if (ton_q == 8'h01) begin
                            on_q[i] <= 1'b0;
                        end
                        ton_q <= ton_q - 1'b1;
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // Outputs and faults
    // ****************************************
    logic [NSTR-1:0] drive_q, oc_q, sc_q;
    logic fault_n_q;
    wire gate_ok = !gated || dim_s2_q;
    wire [NSTR-1:0] drive_d = run ? (on_q & {NSTR{gate_ok}}) : '0;
    wire fault_any = (|open_detect) || (|short_detect);

    // Registered so the string switches see no decode glitches
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            drive_q <= '0;
        end else begin
            drive_q <= drive_d;
        end
    end

    // Flags and fault follow the detectors with no latching, so the
    // fault output releases as soon as the last fault clears
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            oc_q <= '0;
            sc_q <= '0;
            fault_n_q <= 1'b1;
        end else begin
            oc_q <= open_detect;
            sc_q <= short_detect;
            fault_n_q <= !fault_any;
        end
    end
    assign string_cathode_outputs = drive_q;
    assign open_circuit_flags = oc_q;
    assign short_circuit_flags = sc_q;
    assign fault_n = fault_n_q;
endmodule : lspd_dimming

// *** lspd_dimming_bench.sv ***
// Purpose: Directed tests of lspd_dimming
// Assumes: 25 MHz clock, two strings
// Notes: On-time summed over two whole frames, so frame phase does not matter
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin n_errors++; \
    $display("Error %s exp %0h got %0h", n, e, a); end end
module lspd_dimming_bench;
    import lspd_pkg::*;
    localparam int FR = 1000;
    logic clk = 1'b0, sys_rst = 1'b1, enable_pin = 1'b1, drive = 1'b1, ext_dim_pin, fault_n;
    lspd_mode_type dimming_mode = LSPD_MODE_INTERNAL;
    logic [15:0] frame_rate_divider = 16'h0064, count_clock_divider = 16'h0001;
    logic [15:0] string_intensity = 16'h2040, string_phase_delay = 16'h4000;
    logic [5:0] global_intensity = 6'h10, measured_global;
    logic [1:0] open_detect = 2'h0, short_detect = 2'h0, string_cathode_outputs, seen;
    logic [1:0] open_circuit_flags, short_circuit_flags;
    logic [6:0] duty = 7'h00;
    int n_errors = 0, compares = 0, w[2], r[2];
    always #20 clk = ~clk;
    lspd_dimming #(.NSTR(2)) i_lspd_dimming (.*);
    lspd_ctrl_model i_lspd_ctrl_model (.*);
    task automatic run(string nm, int e0, int e1);
        logic [1:0] p;
        w = '{0, 0};
        r = '{-1, -1};
        // Two frames let new settings and the measured duty settle
        repeat (2 * FR) @(negedge clk);
        for (int i = 0; i < 2 * FR; i++) begin
            p = string_cathode_outputs;
            @(negedge clk);
            for (int s = 0; s < 2; s++) begin
                w[s] += int'(string_cathode_outputs[s] === 1'b1);
                if (r[s] < 0 && string_cathode_outputs[s] === 1'b1 && p[s] === 1'b0) r[s] = i;
            end
        end
        `CHK("width0", e0, w[0])
        `CHK("width1", e1, w[1])
        $display("Test %s done", nm);
    endtask : run
    task automatic tally_and_finish();
        $display("Compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        run("internal", 320, 160);
        `CHK("phase", 640, (r[1] - r[0] + FR) % FR)
        dimming_mode = LSPD_MODE_EXTERNAL;
        drive = 1'b0;
        run("external", 1260, 620);
        `CHK("measured", 6'h3F, measured_global)
        dimming_mode = LSPD_MODE_GATED;
        drive = 1'b1;
        run("gated", 0, 0);
        string_intensity = 16'hFFFF;
        string_phase_delay = 16'h0000;
        global_intensity = 6'h3F;
        duty = 7'h64;
        run("gated_full", 2 * FR, 2 * FR);
        dimming_mode = LSPD_MODE_INTERNAL;
        enable_pin = 1'b0;
        run("disabled", 0, 0);
        open_detect = 2'h2;
        repeat (3) @(negedge clk);
        `CHK("fault_n", 1'b0, fault_n)
        `CHK("open_flags", 2'h2, open_circuit_flags)
        `CHK("seen", 2'h2, seen)
        open_detect = 2'h0;
        short_detect = 2'h1;
        repeat (3) @(negedge clk);
        `CHK("short_flags", 2'h1, short_circuit_flags)
        short_detect = 2'h0;
        repeat (3) @(negedge clk);
        `CHK("fault_release", 1'b1, fault_n)
        $display("Test faults done");
        tally_and_finish();
    end
endmodule : lspd_dimming_bench

// *** lspd_dimming_sva.sv ***
// Purpose: Port checks for lspd_dimming
// Assumes: One clock domain
// Notes: Enable window covers the pin synchroniser
`timescale 1ns/1ps
module lspd_dimming_chk #(parameter int NSTR = 8) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic enable_pin,
    input wire logic [NSTR-1:0] open_detect,
    input wire logic [NSTR-1:0] short_detect,
    input wire logic [NSTR-1:0] string_cathode_outputs,
    input wire logic [NSTR-1:0] open_circuit_flags,
    input wire logic [NSTR-1:0] short_circuit_flags,
    input wire logic fault_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic det = |{open_detect, short_detect};
    AST_FAULT_LOW: assert property (det |=> !fault_n) else $error("fault_n high");
    AST_FAULT_REL: assert property (!det |=> fault_n) else $error("fault_n low");
    AST_OPEN_FLAGS: assert property (
        1 |=> open_circuit_flags == $past(open_detect)) else $error("open flags");
    AST_SHORT_FLAGS: assert property (
        1 |=> short_circuit_flags == $past(short_detect)) else $error("short flags");
    AST_FLAG_FAULT: assert property (
        fault_n == !(|{open_circuit_flags, short_circuit_flags})) else $error("flag mix");
    AST_FELL_CAUSE: assert property ($fell(fault_n) |-> $past(det)) else $error("stray");
    AST_ROSE_CAUSE: assert property ($rose(fault_n) |-> !$past(det)) else $error("early");
    AST_ENABLE_OFF: assert property (
        !enable_pin [*5] |-> string_cathode_outputs == '0) else $error("on while off");
    cover property ($rose(string_cathode_outputs[0]));
    cover property ($fell(fault_n));
    cover property (!enable_pin [*5]);
endmodule : lspd_dimming_chk
bind lspd_dimming lspd_dimming_chk #(.NSTR(NSTR)) i_lspd_dimming_chk (.*);

// *** lspd_pkg.sv ***
// Purpose: Constants for the LED string PWM dimming block.
// Assumes: 25 MHz system clock.
// Notes: Mode encodings are one-hot.
package lspd_pkg;
    localparam int STRINGS = 8;
    localparam int INT_W = 8;
    localparam int GLOBAL_W = 6;
    localparam int PHASE_W = 8;
    localparam int FRAME_DIV_W = 16;
    localparam int COUNT_DIV_W = 16;
    localparam int CLK_HZ = 25000000;
    localparam int BASE_HZ = 2500000;
    // Prescale from system clock to the 2.5 MHz base tick
    localparam int BASE_DIV = CLK_HZ / BASE_HZ;
    localparam int BASE_CNT_W = 4;
    localparam logic [GLOBAL_W-1:0] GLOBAL_MAX = 6'h3F;
    localparam logic [FRAME_DIV_W-1:0] FRAME_DIV_RST = 16'h00FA;
    localparam logic [COUNT_DIV_W-1:0] COUNT_DIV_RST = 16'h0008;
    localparam int DUTY_W = 16;
    typedef enum logic [2:0] {
        LSPD_MODE_INTERNAL = 3'h1,
        LSPD_MODE_EXTERNAL = 3'h2,
        LSPD_MODE_GATED    = 3'h4
    } lspd_mode_type;
endpackage : lspd_pkg
